// ===== logic/branch_skip_pkg.sv
// Operation
// - Compare immediate sets flags, one cycle
// - Skip when register bit is clear
// - Skip when register bit set, flags kept
// - Skip when port bit clear, flags kept
// - Skip when port bit is set
// - Generic branch when selected flag set
// - Generic branch when selected flag clear
// - Branch on zero set or clear
// - Branch on carry set or clear
// - Same-or-higher and lower alias carry branches
// - Branch on negative set or clear
// - Signed branches test negative xor overflow
// - Branch on half-carry set or clear
// - Branch on transfer flag set or clear
package branch_skip_pkg;

  // Instruction codes from the decoder
  typedef enum logic [4:0] {
    op_none = 5'h00,
    compare_with_immediate = 5'h01,
    skip_reg_bit_clear = 5'h02,
    skip_reg_bit_set = 5'h03,
    skip_port_bit_clear = 5'h04,
    skip_port_bit_set = 5'h05,
    branch_flag_set_generic = 5'h06,
    branch_flag_clear_generic = 5'h07,
    branch_equal = 5'h08,
    branch_not_equal = 5'h09,
    branch_carry_set = 5'h0A,
    branch_carry_clear = 5'h0B,
    branch_same_or_higher = 5'h0C,
    branch_lower = 5'h0D,
    branch_minus = 5'h0E,
    branch_plus = 5'h0F,
    branch_signed_ge = 5'h10,
    branch_signed_lt = 5'h11,
    branch_half_carry_set = 5'h12,
    branch_half_carry_clear = 5'h13,
    branch_transfer_flag_set = 5'h14,
    branch_transfer_flag_clear = 5'h15
  } op_type;

  // Sequencer states
  typedef enum logic {
    st_idle = 1'b0,
    st_hold = 1'b1
  } state_type;

  // Flag positions in the status flags register
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;

  // Register port offsets
  localparam logic [1:0] ADDR_FLAGS = 2'h0;
  localparam logic [1:0] ADDR_PC_LO = 2'h1;
  localparam logic [1:0] ADDR_PC_HI = 2'h2;

  // Reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Cycle counts and program counter steps
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  localparam logic [15:0] STEP_THREE = 16'h0003;

endpackage

// ===== logic/branch_skip_condition_unit.sv
`timescale 1ns/1ps
module branch_skip_condition_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction issue
  input wire logic issue_valid,
  input wire branch_skip_pkg::op_type issue_op,
  input wire logic [7:0] reg_value,
  input wire logic [7:0] port_value,
  input wire logic [7:0] imm_value,
  input wire logic [2:0] bit_sel,
  input wire logic [6:0] branch_offset,
  input wire logic next_is_two_word,
  // Register port
  input wire logic [1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata_q,
  // Status
  output logic ready_q,
  output logic done_q,
  output logic taken_q,
  output logic [15:0] pc_q,
  output logic [7:0] flags_q
);

  branch_skip_pkg::state_type state_q;
  logic [1:0] count_q;
  logic [15:0] target_q;
  logic accept;
  logic is_cmp;
  logic is_skip;
  logic is_branch;
  logic cond;
  logic [1:0] cycles;
  logic [15:0] target;
  logic [15:0] offset_ext;
  logic [8:0] diff;
  logic [7:0] cmp_flags;

  // Issue is taken only while idle
  assign accept = issue_valid && (state_q == branch_skip_pkg::st_idle);

  // Signed offset widened to the counter width
  assign offset_ext = {{9{branch_offset[6]}}, branch_offset};

  // Compare arithmetic; result is discarded, flags kept
  assign diff = {1'b0, reg_value} - {1'b0, imm_value};

  // Flags produced by the compare
  always_comb begin
    cmp_flags = flags_q;
    cmp_flags[branch_skip_pkg::FLAG_C] = diff[8];
    cmp_flags[branch_skip_pkg::FLAG_Z] = (diff[7:0] == 8'h00);
    cmp_flags[branch_skip_pkg::FLAG_N] = diff[7];
    cmp_flags[branch_skip_pkg::FLAG_V] = (reg_value[7] & ~imm_value[7] & ~diff[7])
      | (~reg_value[7] & imm_value[7] & diff[7]);
    cmp_flags[branch_skip_pkg::FLAG_S] = cmp_flags[branch_skip_pkg::FLAG_N]
      ^ cmp_flags[branch_skip_pkg::FLAG_V];
    cmp_flags[branch_skip_pkg::FLAG_H] = (~reg_value[3] & imm_value[3])
      | (imm_value[3] & diff[3]) | (diff[3] & ~reg_value[3]);
  end

  // Condition decode for every instruction
  always_comb begin
    is_cmp = 1'b0;
    is_skip = 1'b0;
    is_branch = 1'b0;
    cond = 1'b0;
    case (issue_op)
      branch_skip_pkg::compare_with_immediate: begin
        is_cmp = 1'b1;
      end
      branch_skip_pkg::skip_reg_bit_clear: begin
        is_skip = 1'b1;
        cond = ~reg_value[bit_sel];
      end
      branch_skip_pkg::skip_reg_bit_set: begin
        is_skip = 1'b1;
        cond = reg_value[bit_sel];
      end
      branch_skip_pkg::skip_port_bit_clear: begin
        is_skip = 1'b1;
        cond = ~port_value[bit_sel];
      end
      branch_skip_pkg::skip_port_bit_set: begin
        is_skip = 1'b1;
        cond = port_value[bit_sel];
      end
      branch_skip_pkg::branch_flag_set_generic: begin
        is_branch = 1'b1;
        cond = flags_q[bit_sel];
      end
      branch_skip_pkg::branch_flag_clear_generic: begin
        is_branch = 1'b1;
        cond = ~flags_q[bit_sel];
      end
      branch_skip_pkg::branch_equal: begin
        is_branch = 1'b1;
        cond = flags_q[branch_skip_pkg::FLAG_Z];
      end
      branch_skip_pkg::branch_not_equal: begin
        is_branch = 1'b1;
        cond = ~flags_q[branch_skip_pkg::FLAG_Z];
      end
      branch_skip_pkg::branch_carry_set,
      branch_skip_pkg::branch_lower: begin
        is_branch = 1'b1;
        cond = flags_q[branch_skip_pkg::FLAG_C];
      end
      branch_skip_pkg::branch_carry_clear,
      branch_skip_pkg::branch_same_or_higher: begin
        is_branch = 1'b1;
        cond = ~flags_q[branch_skip_pkg::FLAG_C];
      end
      branch_skip_pkg::branch_minus: begin
        is_branch = 1'b1;
        cond = flags_q[branch_skip_pkg::FLAG_N];
      end
      branch_skip_pkg::branch_plus: begin
        is_branch = 1'b1;
        cond = ~flags_q[branch_skip_pkg::FLAG_N];
      end
      branch_skip_pkg::branch_signed_ge: begin
        is_branch = 1'b1;
        cond = ~(flags_q[branch_skip_pkg::FLAG_N]
          ^ flags_q[branch_skip_pkg::FLAG_V]);
      end
      branch_skip_pkg::branch_signed_lt: begin
        is_branch = 1'b1;
        cond = flags_q[branch_skip_pkg::FLAG_N]
          ^ flags_q[branch_skip_pkg::FLAG_V];
      end
      branch_skip_pkg::branch_half_carry_set: begin
        is_branch = 1'b1;
        cond = flags_q[branch_skip_pkg::FLAG_H];
      end
      branch_skip_pkg::branch_half_carry_clear: begin
        is_branch = 1'b1;
        cond = ~flags_q[branch_skip_pkg::FLAG_H];
      end
      branch_skip_pkg::branch_transfer_flag_set: begin
        is_branch = 1'b1;
        cond = flags_q[branch_skip_pkg::FLAG_T];
      end
      branch_skip_pkg::branch_transfer_flag_clear: begin
        is_branch = 1'b1;
        cond = ~flags_q[branch_skip_pkg::FLAG_T];
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // Next program counter
  always_comb begin
    target = pc_q + branch_skip_pkg::STEP_ONE;
    if (is_skip && cond) begin
      if (next_is_two_word) begin
        target = pc_q + branch_skip_pkg::STEP_THREE;
      end else begin
        target = pc_q + branch_skip_pkg::STEP_TWO;
      end
    end else if (is_branch && cond) begin
      target = pc_q + offset_ext + branch_skip_pkg::STEP_ONE;
    end
  end

  // Cycle count of the issued instruction
  always_comb begin
    cycles = branch_skip_pkg::CYC_ONE;
    if (is_skip && cond) begin
      if (next_is_two_word) begin
        cycles = branch_skip_pkg::CYC_THREE;
      end else begin
        cycles = branch_skip_pkg::CYC_TWO;
      end
    end else if (is_branch && cond) begin
      cycles = branch_skip_pkg::CYC_TWO;
    end
  end

  // Sequencer state: holds for multi-cycle instructions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= branch_skip_pkg::st_idle;
    end else if (state_q == branch_skip_pkg::st_idle) begin
      if (accept && (cycles != branch_skip_pkg::CYC_ONE)) begin
        state_q <= branch_skip_pkg::st_hold;
      end
    end else if (count_q == branch_skip_pkg::CYC_ONE) begin
      state_q <= branch_skip_pkg::st_idle;
    end
  end

  // Remaining hold cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 2'h0;
    end else if (state_q == branch_skip_pkg::st_idle) begin
      if (accept && (cycles != branch_skip_pkg::CYC_ONE)) begin
        count_q <= cycles - branch_skip_pkg::CYC_ONE;
      end
    end else begin
      count_q <= count_q - branch_skip_pkg::CYC_ONE;
    end
  end

  // Target kept while the instruction is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      target_q <= branch_skip_pkg::PC_RESET;
    end else if (accept && (cycles != branch_skip_pkg::CYC_ONE)) begin
      target_q <= target;
    end
  end

  // Ready for issue only while idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_q <= 1'b1;
    end else if (state_q == branch_skip_pkg::st_idle) begin
      if (accept && (cycles != branch_skip_pkg::CYC_ONE)) begin
        ready_q <= 1'b0;
      end
    end else if (count_q == branch_skip_pkg::CYC_ONE) begin
      ready_q <= 1'b1;
    end
  end

  // Program counter; hardware update beats a software load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= branch_skip_pkg::PC_RESET;
    end else if (accept && (cycles == branch_skip_pkg::CYC_ONE)) begin
      pc_q <= target;
    end else if ((state_q == branch_skip_pkg::st_hold)
        && (count_q == branch_skip_pkg::CYC_ONE)) begin
      pc_q <= target_q;
    end else if (bus_wr && (state_q == branch_skip_pkg::st_idle)) begin
      if (bus_addr == branch_skip_pkg::ADDR_PC_LO) begin
        pc_q[7:0] <= bus_wdata;
      end else if (bus_addr == branch_skip_pkg::ADDR_PC_HI) begin
        pc_q[15:8] <= bus_wdata;
      end
    end
  end

  // Status flags; only the compare and a bus write to the flags offset change them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= branch_skip_pkg::FLAGS_RESET;
    end else if (accept && is_cmp) begin
      flags_q <= cmp_flags;
    end else if (bus_wr && (bus_addr == branch_skip_pkg::ADDR_FLAGS)) begin
      flags_q <= bus_wdata;
    end
  end

  // Completion pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (accept && (cycles == branch_skip_pkg::CYC_ONE)) begin
      done_q <= 1'b1;
    end else if ((state_q == branch_skip_pkg::st_hold)
        && (count_q == branch_skip_pkg::CYC_ONE)) begin
      done_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
    end
  end

  // Taken indication, only at the end of a held instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      taken_q <= 1'b0;
    end else if ((state_q == branch_skip_pkg::st_hold)
        && (count_q == branch_skip_pkg::CYC_ONE)) begin
      taken_q <= 1'b1;
    end else begin
      taken_q <= 1'b0;
    end
  end

  // Register read data, valid the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rdata_q <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        branch_skip_pkg::ADDR_FLAGS: bus_rdata_q <= flags_q;
        branch_skip_pkg::ADDR_PC_LO: bus_rdata_q <= pc_q[7:0];
        branch_skip_pkg::ADDR_PC_HI: bus_rdata_q <= pc_q[15:8];
        default: bus_rdata_q <= 8'h00;
      endcase
    end else begin
      bus_rdata_q <= 8'h00;
    end
  end

endmodule // branch_skip_condition_unit

// ===== bench/branch_skip_condition_unit_asserts.sv
`timescale 1ns/1ps
module branch_skip_condition_unit_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Issue and bus
  input wire logic issue_valid,
  input wire branch_skip_pkg::op_type issue_op,
  input wire logic [7:0] reg_value,
  input wire logic [7:0] imm_value,
  input wire logic [2:0] bit_sel,
  input wire logic [6:0] branch_offset,
  input wire logic next_is_two_word,
  input wire logic bus_wr,
  // Status
  input wire logic ready_q,
  input wire logic done_q,
  input wire logic taken_q,
  input wire logic [15:0] pc_q,
  input wire logic [7:0] flags_q
);
  logic [15:0] k_ext;
  // Signed offset widened to the counter
  assign k_ext = {{9{branch_offset[6]}}, branch_offset};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted issue; a held cycle ending in a taken completion
  sequence acc_s;
    issue_valid && ready_q;
  endsequence
  sequence held_s;
    !ready_q ##1 done_q && taken_q;
  endsequence
  chk_taken_done:
    assert property (taken_q |-> done_q) else $error("taken without done");
  chk_hold_ends:
    assert property ($fell(ready_q) |-> ##[1:2] ready_q && done_q) else $error("hold too long");
  chk_taken_waits:
    assert property (taken_q |-> $past(ready_q) == 1'b0) else $error("taken in one cycle");
  chk_plain_step:
    assert property (acc_s |=> !done_q || taken_q || pc_q == $past(pc_q) + 16'h0001) else $error("bad step");
  chk_skip_three:
    assert property (acc_s ##0 issue_op == branch_skip_pkg::skip_reg_bit_set && reg_value[bit_sel]
      && next_is_two_word |=> !ready_q ##1 held_s ##0 pc_q == $past(pc_q, 3) + 16'h0003) else $error("bad skip");
  chk_branch_target:
    assert property (acc_s ##0 issue_op == branch_skip_pkg::branch_equal && flags_q[1]
      |=> held_s ##0 pc_q == $past(pc_q, 2) + $past(k_ext, 2) + 16'h0001) else $error("bad target");
  chk_compare_flags:
    assert property (acc_s ##0 issue_op == branch_skip_pkg::compare_with_immediate |=> done_q && !taken_q
      && flags_q[1:0] == {$past(reg_value) == $past(imm_value), $past(reg_value) < $past(imm_value)})
      else $error("bad compare");
  chk_flags_kept:
    assert property (!ready_q && !bus_wr |=> $stable(flags_q)) else $error("flags changed");
  chk_signed_lt:
    assert property (acc_s ##0 issue_op == branch_skip_pkg::branch_signed_lt && (flags_q[2] ^ flags_q[3])
      |=> held_s) else $error("signed branch missed");
endmodule // branch_skip_condition_unit_asserts
bind branch_skip_condition_unit branch_skip_condition_unit_asserts u_chk (.clk, .rst, .issue_valid, .issue_op,
  .reg_value, .imm_value, .bit_sel, .branch_offset, .next_is_two_word, .bus_wr, .ready_q, .done_q, .taken_q,
  .pc_q, .flags_q);

// ===== bench/branch_skip_decoder_model.sv
`timescale 1ns/1ps
module branch_skip_decoder_model (
  // Clock and completion
  input wire logic clk,
  input wire logic done_q,
  // Issue fields
  output logic issue_valid = 1'b0,
  output branch_skip_pkg::op_type issue_op = branch_skip_pkg::op_none,
  output logic [7:0] reg_value = 8'h00,
  output logic [7:0] port_value = 8'h00,
  output logic [7:0] imm_value = 8'h00,
  output logic [2:0] bit_sel = 3'h0,
  output logic [6:0] branch_offset = 7'h00,
  output logic next_is_two_word = 1'b0
);
  // One issue pulse; operands scrambled once released so late sampling shows
  task automatic issue(input branch_skip_pkg::op_type op, input logic [7:0] r, p, i, input logic [2:0] b,
    input logic [6:0] k, input logic tw, output int n);
    @(posedge clk);
    issue_valid <= 1'b1;
    issue_op <= op;
    reg_value <= r;
    port_value <= p;
    imm_value <= i;
    bit_sel <= b;
    branch_offset <= k;
    next_is_two_word <= tw;
    @(posedge clk);
    issue_valid <= 1'b0;
    reg_value <= ~r;
    port_value <= ~p;
    imm_value <= ~i;
    branch_offset <= ~k;
    n = 1;
    #1;
    while (done_q !== 1'b1 && n < 5) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
endmodule // branch_skip_decoder_model

// ===== bench/branch_skip_condition_unit_tb.sv
`timescale 1ns/1ps
module branch_skip_condition_unit_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [1:0] bus_addr = 2'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic issue_valid, next_is_two_word, ready_q, done_q, taken_q, v, t;
  logic [7:0] reg_value, port_value, imm_value, bus_rdata_q, flags_q, fl, rv, d;
  logic [2:0] bit_sel;
  logic [6:0] branch_offset, k;
  logic [15:0] pc_q, pc_e;
  logic [7:0] ca [4] = '{8'h05, 8'h03, 8'h80, 8'h10};
  logic [7:0] cb [4] = '{8'h05, 8'h05, 8'h01, 8'h01};
  branch_skip_pkg::op_type issue_op;
  int errors = 0;
  int total_checks = 0;
  int n;
  // Clock at 40 ns
  always #20 clk = ~clk;
  branch_skip_condition_unit DUT (.clk, .rst, .issue_valid, .issue_op, .reg_value, .port_value, .imm_value,
    .bit_sel, .branch_offset, .next_is_two_word, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_q,
    .ready_q, .done_q, .taken_q, .pc_q, .flags_q);
  branch_skip_decoder_model dec (.clk, .done_q, .issue_valid, .issue_op, .reg_value, .port_value,
    .imm_value, .bit_sel, .branch_offset, .next_is_two_word);
  // One comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One write or read cycle; read data lands in rv
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] dt);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= dt;
    bus_wr <= w;
    bus_rd <= !w;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    #1;
    rv = bus_rdata_q;
  endtask
  // Branch condition per instruction code
  function automatic logic take(input logic [4:0] op, input logic [7:0] f, input logic [2:0] b);
    case (op)
      5'h06, 5'h07: take = f[b] ^ op[0];
      5'h08, 5'h09: take = f[1] ^ op[0];
      5'h0A, 5'h0B: take = f[0] ^ op[0];
      5'h0C, 5'h0D: take = f[0] ^ !op[0];
      5'h0E, 5'h0F: take = f[2] ^ op[0];
      5'h10, 5'h11: take = f[2] ^ f[3] ^ !op[0];
      5'h12, 5'h13: take = f[5] ^ op[0];
      default: take = f[6] ^ op[0];
    endcase
  endfunction
  // Issue one instruction and compare its outcome
  task automatic run(input branch_skip_pkg::op_type op, input logic [7:0] r, i, input logic [2:0] b,
    input logic [6:0] kk, input logic tw, tk, input logic [15:0] step);
    dec.issue(op, r, r ^ {8{op < 5'h04}}, i, b, kk, tw, n);
    pc_e = pc_e + step;
    check(16'(taken_q), 16'(tk));
    check(16'(n), !tk ? 16'h0001 : op < 5'h06 ? step : 16'h0002);
    check(pc_q, pc_e);
    check(16'(flags_q), 16'(fl));
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(pc_q, 16'h0000);
    check(16'({ready_q, flags_q}), 16'h0100);
    check(16'({done_q, taken_q, bus_rdata_q}), 16'h0000);
    bus(1'b1, 2'h1, 8'h34);
    bus(1'b1, 2'h2, 8'h12);
    bus(1'b1, 2'h0, 8'h5A);
    bus(1'b0, 2'h0, 8'h00);
    check(16'(rv), 16'h005A);
    bus(1'b0, 2'h3, 8'h00);
    check(16'(rv), 16'h0000);
    check(pc_q, 16'h1234);
    pc_e = 16'h1234;
    fl = 8'h5A;
    for (int c = 0; c < 4; c++) begin
      d = ca[c] - cb[c];
      v = ca[c][7] & !cb[c][7] & !d[7] | !ca[c][7] & cb[c][7] & d[7];
      fl = {fl[7:6], ca[c][3:0] < cb[c][3:0], d[7] ^ v, v, d[7], d == 8'h00, ca[c] < cb[c]};
      run(branch_skip_pkg::compare_with_immediate, ca[c], cb[c], 3'h0, 7'h00, 1'b0, 1'b0, 16'h0001);
    end
    run(branch_skip_pkg::op_none, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 1'b0, 16'h0001);
    for (int s = 2; s < 6; s++)
      for (int m = 0; m < 4; m++) begin
        t = m[0] ^ !s[0];
        run(branch_skip_pkg::op_type'(s), m[0] ? 8'h10 : 8'hEF, 8'h00, 3'h4, 7'h00, m[1], t,
          t ? 16'(2 + m[1]) : 16'h0001);
      end
    for (int p = 0; p < 9; p++) begin
      fl = p == 0 ? 8'h00 : p == 8 ? 8'h0C : 8'h01 << (p - 1);
      bus(1'b1, 2'h0, fl);
      for (int o = 6; o < 22; o++) begin
        t = take(o[4:0], fl, 3'(p ^ 1));
        k = p[0] ? 7'h7E : 7'h05;
        run(branch_skip_pkg::op_type'(o), 8'h00, 8'h00, 3'(p ^ 1), k, 1'b0, t,
          t ? {{9{k[6]}}, k} + 16'h0001 : 16'h0001);
      end
    end
    complete_run;
  end
  // Watchdog
  initial begin
    #200000;
    errors++;
    complete_run;
  end
endmodule // branch_skip_condition_unit_tb
